// ==== test/dfs_reset_host.sv ====
// model of panel key, digital reset input, serial host and mains
`default_nettype none
module dfs_reset_host (
	// clock
	input  wire logic clk_sys_i,
	// reset requests and mains state
	output logic      panel_reset_o,
	output logic      din_reset_o,
	output logic      serial_reset_o,
	output logic      mains_ok_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// idle levels at time zero
	initial begin
		panel_reset_o = 1'b0;
		din_reset_o = 1'b0;
		serial_reset_o = 1'b0;
		mains_ok_o = 1'b1;
	end
	// one-cycle request from source 0 panel, 1 input, 2 serial
	task automatic pulse(input int src);
		@(negedge clk_sys_i);
		panel_reset_o = (src == 0);
		din_reset_o = (src == 1);
		serial_reset_o = (src == 2);
		@(negedge clk_sys_i);
		panel_reset_o = 1'b0;
		din_reset_o = 1'b0;
		serial_reset_o = 1'b0;
	endtask
	// mains removed for one cycle, as a lock needs before reset
	task automatic power_cycle();
		@(negedge clk_sys_i);
		mains_ok_o = 1'b0;
		@(negedge clk_sys_i);
		mains_ok_o = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== test/dfs_supervisor_properties.sv ====
// concurrent checks on the ports of the drive fault supervisor
`default_nettype none
module dfs_supervisor_chk
	import dfs_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int OVER_LEN = OVER_TICKS
) (
	// clock and reset
	input wire logic       clk_sys_i,
	input wire logic       reset_n_i,
	// inputs watched
	input wire logic [9:0] dc_link_voltage_i,
	input wire logic [6:0] inv_thermal_pct_i,
	input wire logic       ext_fault_active_i,
	input wire logic [6:0] ext_fault_code_i,
	input wire logic       auto_reset_en_i,
	input wire logic       panel_reset_i,
	input wire logic       din_reset_i,
	input wire logic       serial_reset_i,
	// outputs watched
	input wire logic       warning_led_o,
	input wire logic       alarm_led_o,
	input wire logic       tripped_o,
	input wire logic       trip_locked_o,
	input wire logic       coast_o,
	input wire logic       inverter_off_o,
	input wire logic       ready_o,
	input wire logic [6:0] trip_code_o
);
	// ==========================================================
	// helpers
	// margin of two ticks plus four cycles covers phase slip and the output stages
	localparam int OV_LIM = (OVER_LEN + 2) * TICK_DIV + 4;
	logic [TMR_W-1:0] ov_cnt_reg;
	wire logic        no_req;
	assign no_req = !panel_reset_i && !din_reset_i && !serial_reset_i
		&& !auto_reset_en_i;
	// cycles spent above the overvoltage limit, saturating
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ov_cnt_reg <= '0;
		else if (dc_link_voltage_i <= V_OVER)
			ov_cnt_reg <= '0;
		else if (ov_cnt_reg != '1)
			ov_cnt_reg <= ov_cnt_reg + 1'b1;
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_lock_req;
		ext_fault_active_i && ext_fault_code_i == 7'h0e;
	endsequence
	sequence s_locked;
		tripped_o && trip_locked_o;
	endsequence
	property p_coast;
		coast_o == tripped_o;
	endproperty
	property p_ready;
		$past(reset_n_i) |-> ready_o == !tripped_o;
	endproperty
	property p_alarm;
		alarm_led_o |-> tripped_o || $past(tripped_o);
	endproperty
	property p_lock_lamps;
		trip_locked_o && $past(trip_locked_o) && alarm_led_o |-> warning_led_o;
	endproperty
	property p_lock_hold;
		trip_locked_o && no_req && $past(no_req) && $past(no_req, 2)
			|=> trip_locked_o;
	endproperty
	property p_lock_trip;
		s_lock_req |-> ##2 s_locked;
	endproperty
	property p_over_off;
		dc_link_voltage_i > V_OVER |-> ##[1:2] inverter_off_o;
	endproperty
	property p_under_off;
		dc_link_voltage_i < V_UNDER |-> ##[1:2] inverter_off_o;
	endproperty
	property p_over_trip;
		int'(ov_cnt_reg) > OV_LIM |-> tripped_o;
	endproperty
	property p_inv_trip;
		inv_thermal_pct_i >= PCT_TRIP |-> ##[1:3] tripped_o;
	endproperty
	property p_code;
		tripped_o == (trip_code_o != CODE_NONE);
	endproperty
	a_coast: assert property (p_coast) else $error("coast differs from trip");
	a_ready: assert property (p_ready) else $error("ready not inverse of trip");
	a_alarm: assert property (p_alarm) else $error("alarm lamp without trip");
	a_lock_lamps: assert property (p_lock_lamps) else $error("lock lamps apart");
	a_lock_hold: assert property (p_lock_hold) else $error("lock lost unasked");
	a_lock_trip: assert property (p_lock_trip) else $error("no lock on code");
	a_over_off: assert property (p_over_off) else $error("inverter on above");
	a_under_off: assert property (p_under_off) else $error("inverter on below");
	a_over_trip: assert property (p_over_trip) else $error("overvolt no trip");
	a_inv_trip: assert property (p_inv_trip) else $error("thermal no trip");
	a_code: assert property (p_code) else $error("trip code mismatch");
endmodule
bind dfs_supervisor dfs_supervisor_chk #(
	.TICK_DIV(TICK_DIV),
	.OVER_LEN(OVER_LEN)
) u_chk (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.dc_link_voltage_i(dc_link_voltage_i),
	.inv_thermal_pct_i(inv_thermal_pct_i),
	.ext_fault_active_i(ext_fault_active_i),
	.ext_fault_code_i(ext_fault_code_i),
	.auto_reset_en_i(auto_reset_en_i),
	.panel_reset_i(panel_reset_i),
	.din_reset_i(din_reset_i),
	.serial_reset_i(serial_reset_i),
	.warning_led_o(warning_led_o),
	.alarm_led_o(alarm_led_o),
	.tripped_o(tripped_o),
	.trip_locked_o(trip_locked_o),
	.coast_o(coast_o),
	.inverter_off_o(inverter_off_o),
	.ready_o(ready_o),
	.trip_code_o(trip_code_o)
);
`default_nettype wire

// ==== test/tb_dfs_supervisor.sv ====
// self-checking testbench of the drive fault supervisor
`default_nettype none
module tb_dfs_supervisor import dfs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// stimulus and observed signals
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  vdc = 10'h258;
	logic [11:0] ain = 12'h0c8, ain_min = 12'h064;
	logic [6:0]  inv_pct = 7'h00, mot_pct = 7'h00, ext_code = 7'h00;
	logic        ph_loss = 1'b0, ext_act = 1'b0, ext_alm = 1'b0;
	logic        brake = 1'b0, three_ph = 1'b1, mot_alm = 1'b0;
	logic        lz_alm = 1'b0, auto_en = 1'b0, a_seen, w_seen;
	logic        pnl, din, ser, mains, warn_led, alm_led, tripped;
	logic        locked, inv_off, ready, coast;
	logic [6:0]  trip_code, last_code;
	int          error_cnt = 0, cmp_count = 0;
	localparam logic [6:0] CODES [25] = '{7'h05, 7'h06, 7'h21, 7'h63,
		7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h11, 7'h12, 7'h22, 7'h24,
		7'h0e, 7'h0f, 7'h10, 7'h23, 7'h25, 7'h29, 7'h2d, 7'h32, 7'h33,
		7'h36, 7'h37, 7'h38};
	// short counts keep the run brief
	always #50 clk = ~clk;
	dfs_reset_host host (.clk_sys_i(clk), .panel_reset_o(pnl),
		.din_reset_o(din), .serial_reset_o(ser), .mains_ok_o(mains));
	dfs_supervisor #(.TICK_DIV(4), .BLINK_LEN(2), .V_HIGH_LEN(5),
		.V_LOW_LEN(5), .OVER_LEN(5)) uut (
		.clk_sys_i(clk), .reset_n_i(rst_n), .dc_link_voltage_i(vdc),
		.ain_value_i(ain), .ain_min_i(ain_min), .phase_loss_i(ph_loss),
		.inv_thermal_pct_i(inv_pct), .mot_thermal_pct_i(mot_pct),
		.mains_ok_i(mains), .ext_fault_active_i(ext_act),
		.ext_fault_code_i(ext_code), .ext_fault_alarm_i(ext_alm),
		.brake_fitted_i(brake), .three_phase_i(three_ph),
		.mot_thermal_alarm_i(mot_alm), .live_zero_alarm_i(lz_alm),
		.auto_reset_en_i(auto_en), .panel_reset_i(pnl),
		.din_reset_i(din), .serial_reset_i(ser),
		.warning_led_o(warn_led), .alarm_led_o(alm_led),
		.tripped_o(tripped), .trip_locked_o(locked), .coast_o(coast),
		.inverter_off_o(inv_off), .ready_o(ready),
		.trip_code_o(trip_code), .last_fault_code_o(last_code));
	// ==========================================================
	// helpers
	function automatic logic is_lock(input logic [6:0] c);
		return c inside {7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h23, [7'h25:7'h2d]};
	endfunction
	function automatic logic warn_only(input logic [6:0] c);
		return c inside {7'h05, 7'h06, 7'h21, 7'h63};
	endfunction
	function automatic logic no_warn(input logic [6:0] c);
		return is_lock(c) && c != 7'h0d || c inside {[7'h32:7'h38]};
	endfunction
	// wide enough for the grouped compares of flags and codes
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic till_trip(input int n);
		for (int i = 0; i < n && tripped !== 1'b1; i++) @(negedge clk);
	endtask
	// lamps are sampled over more than one blink period
	task automatic lamps(input int n);
		a_seen = 1'b0;
		w_seen = 1'b0;
		repeat (n) begin
			@(negedge clk);
			a_seen |= alm_led;
			w_seen |= warn_led;
		end
	endtask
	task automatic clr(input int src);
		host.power_cycle();
		host.pulse(src);
		cyc(3);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_codes();
		logic [6:0] c;
		logic       t;
		for (int a = 0; a < 2; a++) begin
			for (int i = 0; i < 25; i++) begin
				c = CODES[i];
				t = !warn_only(c) && (a == 1 || no_warn(c));
				ext_code = c;
				ext_alm = a[0];
				ext_act = 1'b1;
				lamps(20);
				chk(7'(tripped), 7'(t));
				chk(7'(coast), 7'(t));
				chk(7'(locked), 7'(t && is_lock(c)));
				chk({5'h00, a_seen, w_seen}, {5'h00, t, 1'b1});
				chk(t ? trip_code : last_code, c);
				ext_act = 1'b0;
				cyc(2);
				lamps(20);
				chk({a_seen, w_seen}, {t, t && is_lock(c)});
				clr(i % 3);
				chk(7'(ready), 7'h01);
			end
		end
		$display("fault class test done");
	endtask
	task automatic t_auto();
		auto_en = 1'b1;
		ext_code = 7'h32;
		ext_act = 1'b1;
		cyc(4);
		ext_act = 1'b0;
		cyc(4);
		chk(7'(ready), 7'h01);
		auto_en = 1'b0;
		ext_code = 7'h0e;
		ext_act = 1'b1;
		cyc(4);
		ext_act = 1'b0;
		host.pulse(1);
		cyc(3);
		chk(7'(locked), 7'h01);
		auto_en = 1'b1;
		host.power_cycle();
		cyc(4);
		chk(7'(tripped), 7'h00);
		auto_en = 1'b0;
		$display("auto reset test done");
	endtask
	task automatic t_volt();
		vdc = 10'h33e;
		cyc(3);
		chk(7'(inv_off), 7'h01);
		till_trip(80);
		chk(trip_code, CODE_OVERVOLT);
		vdc = 10'h30c;
		brake = 1'b1;
		clr(1);
		lamps(20);
		chk(7'(w_seen), 7'h00);
		brake = 1'b0;
		// look before the high-warning timer can expire and trip
		cyc(3);
		chk(last_code, CODE_V_HIGH);
		till_trip(80);
		chk(trip_code, CODE_OVERVOLT);
		vdc = 10'h1ae;
		clr(2);
		chk({inv_off, tripped, last_code}, {2'h0, CODE_V_LOW});
		till_trip(80);
		chk(trip_code, CODE_UNDERVOLT);
		vdc = 10'h190;
		clr(0);
		chk(7'(inv_off), 7'h01);
		vdc = 10'h258;
		clr(0);
		$display("dc-link test done");
	endtask
	task automatic t_inputs();
		inv_pct = 7'h62;
		cyc(3);
		chk({tripped, last_code}, {1'b0, CODE_INV_LOAD});
		inv_pct = 7'h64;
		cyc(3);
		inv_pct = 7'h5f;
		clr(0);
		chk(trip_code, CODE_INV_LOAD);
		inv_pct = 7'h55;
		clr(0);
		chk(7'(tripped), 7'h00);
		mot_pct = 7'h64;
		cyc(3);
		chk({tripped, last_code}, {1'b0, CODE_MOT_LOAD});
		mot_alm = 1'b1;
		cyc(3);
		chk(trip_code, CODE_MOT_LOAD);
		mot_pct = 7'h00;
		lz_alm = 1'b1;
		ain = 12'h032;
		clr(1);
		chk(7'(tripped), 7'h00);
		ain = 12'h031;
		cyc(3);
		chk(trip_code, CODE_LIVE_ZERO);
		// full-scale minimum: 12'h800 just above half passes, 12'h7ff just below trips
		ain_min = 12'hfff;
		ain = 12'h800;
		clr(1);
		chk(7'(tripped), 7'h00);
		ain = 12'h7ff;
		cyc(3);
		chk(trip_code, CODE_LIVE_ZERO);
		ain_min = 12'h064;
		ain = 12'h0c8;
		three_ph = 1'b0;
		ph_loss = 1'b1;
		clr(2);
		chk(7'(tripped), 7'h00);
		three_ph = 1'b1;
		cyc(3);
		chk(trip_code, CODE_PHASE);
		ph_loss = 1'b0;
		clr(0);
		$display("thermal and input test done");
	endtask
	// ==========================================================
	// verdict, main sequence and watchdog
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		cyc(20);
		rst_n = 1'b1;
		cyc(2);
		t_codes();
		t_auto();
		t_volt();
		t_inputs();
		summarize();
	end
	initial begin
		#2000000;
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire

// ==== verilog/dfs_persist_timer.sv ====
// persistence timer: expires after a condition holds for a tick count
`default_nettype none
module dfs_persist_timer
	import dfs_pkg::*;
#(
	parameter int W     = TMR_W,
	parameter int LIMIT = 1000
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic reset_n_i,
	// timing
	input  wire logic tick_i,
	input  wire logic cond_i,
	// result
	output logic      expired_o
);
	logic [W-1:0] cnt_reg;
	wire          at_limit = (cnt_reg == W'(LIMIT - 1));

	// counts ticks while the condition stays, restarts when it drops
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_reg   <= '0;
			expired_o <= 1'b0;
		end else if (!cond_i) begin
			cnt_reg   <= '0;
			expired_o <= 1'b0;
		end else if (tick_i && !expired_o) begin
			cnt_reg   <= at_limit ? cnt_reg : cnt_reg + W'(1);
			expired_o <= at_limit;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/dfs_pkg.sv ====
// constants shared by the drive fault supervisor
`default_nettype none
package dfs_pkg;
	// ==========================================================
	// fault codes
	localparam logic [6:0] CODE_NONE      = 7'h00;
	localparam logic [6:0] CODE_LIVE_ZERO = 7'h02;
	localparam logic [6:0] CODE_PHASE     = 7'h04;
	localparam logic [6:0] CODE_V_HIGH    = 7'h05;
	localparam logic [6:0] CODE_V_LOW     = 7'h06;
	localparam logic [6:0] CODE_OVERVOLT  = 7'h07;
	localparam logic [6:0] CODE_UNDERVOLT = 7'h08;
	localparam logic [6:0] CODE_INV_LOAD  = 7'h09;
	localparam logic [6:0] CODE_MOT_LOAD  = 7'h0a;
	// ==========================================================
	// dc-link thresholds in volts
	localparam logic [9:0] V_UNDER      = 10'h19a; // 410
	localparam logic [9:0] V_WARN_LOW   = 10'h1b8; // 440
	localparam logic [9:0] V_WARN_HI    = 10'h2fd; // 765
	localparam logic [9:0] V_WARN_HI_BR = 10'h320; // 800
	localparam logic [9:0] V_OVER       = 10'h334; // 820
	// ==========================================================
	// thermal counter levels in percent
	localparam logic [6:0] PCT_INV_WARN  = 7'h62; // 98
	localparam logic [6:0] PCT_TRIP      = 7'h64; // 100
	localparam logic [6:0] PCT_INV_RESET = 7'h5a; // 90
	// ==========================================================
	// timing
	localparam int CLK_HZ        = 10000000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int BLINK_MS      = 250;
	localparam int BLINK_TICKS   = BLINK_MS / TICK_MS;
	localparam int V_HIGH_MS     = 5000; // device range 5 to 10 s
	localparam int V_LOW_MS      = 2000; // device range 2 to 25 s
	localparam int OVER_MS       = 5000; // device range 5 to 10 s
	localparam int UNDER_MS      = 2000; // device range 2 to 15 s
	localparam int V_HIGH_TICKS  = V_HIGH_MS / TICK_MS;
	localparam int V_LOW_TICKS   = V_LOW_MS / TICK_MS;
	localparam int OVER_TICKS    = OVER_MS / TICK_MS;
	localparam int UNDER_TICKS   = UNDER_MS / TICK_MS;
	localparam int TMR_W         = 16;
	// ==========================================================
	// trip sources, in priority order
	typedef enum logic [2:0] {
		SRC_EXT, SRC_OVER, SRC_UNDER, SRC_LZ, SRC_PHASE, SRC_INV,
		SRC_MOT, SRC_NONE
	} dfs_src_t;
endpackage
`default_nettype wire

// ==== verilog/dfs_supervisor.sv ====
// drive fault supervisor: fault classes, dc-link, thermal, trip reset
// ============================================================
`default_nettype none
module dfs_supervisor
	import dfs_pkg::*;
#(
	parameter int TICK_DIV    = TICK_CYCLES,
	parameter int BLINK_LEN   = BLINK_TICKS,
	parameter int V_HIGH_LEN  = V_HIGH_TICKS,
	parameter int V_LOW_LEN   = V_LOW_TICKS,
	parameter int OVER_LEN    = OVER_TICKS,
	parameter int UNDER_LEN   = UNDER_TICKS,
	parameter int AIN_W       = 12
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	// measurements
	input  wire logic [9:0]       dc_link_voltage_i,
	input  wire logic [AIN_W-1:0] ain_value_i,
	input  wire logic [AIN_W-1:0] ain_min_i,
	input  wire logic             phase_loss_i,
	input  wire logic [6:0]       inv_thermal_pct_i,
	input  wire logic [6:0]       mot_thermal_pct_i,
	input  wire logic             mains_ok_i,
	// faults detected elsewhere
	input  wire logic             ext_fault_active_i,
	input  wire logic [6:0]       ext_fault_code_i,
	input  wire logic             ext_fault_alarm_i,
	// configuration
	input  wire logic             brake_fitted_i,
	input  wire logic             three_phase_i,
	input  wire logic             mot_thermal_alarm_i,
	input  wire logic             live_zero_alarm_i,
	input  wire logic             auto_reset_en_i,
	// reset requests, one-cycle pulses
	input  wire logic             panel_reset_i,
	input  wire logic             din_reset_i,
	input  wire logic             serial_reset_i,
	// indicators and drive control
	output logic                  warning_led_o,
	output logic                  alarm_led_o,
	output logic                  tripped_o,
	output logic                  trip_locked_o,
	output logic                  coast_o,
	output logic                  inverter_off_o,
	output logic                  ready_o,
	output logic [6:0]            trip_code_o,
	output logic [6:0]            last_fault_code_o
);
	// ========================================================
	// fault classification: {may warn, may alarm, locks}
	function automatic logic [2:0] fault_class(input logic [6:0] c);
		logic [2:0] r;
		r = 3'h0;
		case (c)
			7'd2, 7'd4, 7'd7, 7'd8, 7'd13: r = 3'h7;
			7'd14, 7'd15, 7'd16, 7'd35:    r = 3'h3;
			7'd5, 7'd6, 7'd33, 7'd99:      r = 3'h4;
			7'd50, 7'd51, 7'd54, 7'd55,
			7'd56:                         r = 3'h2;
			7'd9, 7'd10, 7'd11, 7'd12,
			7'd17, 7'd18, 7'd34, 7'd36:    r = 3'h6;
			default: begin
				if (c >= 7'd37 && c <= 7'd45)
					r = 3'h3;
			end
		endcase
		return r;
	endfunction

	function automatic logic [6:0] src_code(input dfs_src_t s,
		input logic [6:0] ext);
		logic [6:0] r;
		r = CODE_NONE;
		case (s)
			SRC_EXT:   r = ext;
			SRC_OVER:  r = CODE_OVERVOLT;
			SRC_UNDER: r = CODE_UNDERVOLT;
			SRC_LZ:    r = CODE_LIVE_ZERO;
			SRC_PHASE: r = CODE_PHASE;
			SRC_INV:   r = CODE_INV_LOAD;
			SRC_MOT:   r = CODE_MOT_LOAD;
			default:   r = CODE_NONE;
		endcase
		return r;
	endfunction

	// ========================================================
	// millisecond tick and blink phase
	logic [15:0] div_reg;
	logic        tick_reg;
	logic [15:0] blink_cnt_reg;
	logic        blink_reg;

	wire div_end   = (div_reg == 16'(TICK_DIV - 1));
	wire blink_end = (blink_cnt_reg == 16'(BLINK_LEN - 1));

	// one enable pulse per millisecond; lamps share one phase
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_end ? 16'h0000 : div_reg + 16'h0001;
			tick_reg <= div_end;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			blink_cnt_reg <= 16'h0000;
			blink_reg     <= 1'b0;
		end else if (tick_reg) begin
			blink_cnt_reg <= blink_end ? 16'h0000
				: blink_cnt_reg + 16'h0001;
			if (blink_end)
				blink_reg <= ~blink_reg;
		end
	end

	// ========================================================
	// dc-link comparators
	wire [9:0] hi_lim  = brake_fitted_i ? V_WARN_HI_BR : V_WARN_HI;
	wire v_over  = dc_link_voltage_i > V_OVER;
	wire v_high  = dc_link_voltage_i > hi_lim;
	wire v_low   = dc_link_voltage_i < V_WARN_LOW;
	wire v_under = dc_link_voltage_i < V_UNDER;
	wire t_high, t_low, t_over, t_under;

	// persistence timers for the four voltage bands
	dfs_persist_timer #(.W(TMR_W), .LIMIT(V_HIGH_LEN)) u_t_high (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_reg),
		.cond_i    (v_high),
		.expired_o (t_high)
	);
	dfs_persist_timer #(.W(TMR_W), .LIMIT(V_LOW_LEN)) u_t_low (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_reg),
		.cond_i    (v_low),
		.expired_o (t_low)
	);
	dfs_persist_timer #(.W(TMR_W), .LIMIT(OVER_LEN)) u_t_over (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_reg),
		.cond_i    (v_over),
		.expired_o (t_over)
	);
	dfs_persist_timer #(.W(TMR_W), .LIMIT(UNDER_LEN)) u_t_under (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_reg),
		.cond_i    (v_under),
		.expired_o (t_under)
	);

	// ========================================================
	// other fault conditions
	// half of minimum scaling, compared without losing the low bit
	wire [AIN_W:0] ain_x2 = {ain_value_i, 1'b0};
	wire lz_live   = ({1'b0, ain_x2[AIN_W-1:0]} < {1'b0, ain_min_i})
		& ~ain_value_i[AIN_W-1];
	wire ph_live   = phase_loss_i & three_phase_i;
	wire inv_warn  = inv_thermal_pct_i >= PCT_INV_WARN;
	wire inv_trip  = inv_thermal_pct_i >= PCT_TRIP;
	wire inv_hold  = inv_thermal_pct_i >= PCT_INV_RESET;
	wire mot_full  = mot_thermal_pct_i >= PCT_TRIP;

	wire [2:0] ext_cls = fault_class(ext_fault_code_i);
	// a two-stage code warns first and trips on its alarm stage
	wire ext_warn = ext_fault_active_i & ext_cls[2];
	wire ext_trip = ext_fault_active_i & ext_cls[1]
		& (~ext_cls[2] | ext_fault_alarm_i);

	// ========================================================
	// trip requests and live causes per source
	logic [6:0] trip_req;
	logic [6:0] src_live;
	assign trip_req[SRC_EXT]   = ext_trip;
	assign trip_req[SRC_OVER]  = t_over | t_high;
	assign trip_req[SRC_UNDER] = t_under | t_low;
	assign trip_req[SRC_LZ]    = lz_live & live_zero_alarm_i;
	assign trip_req[SRC_PHASE] = ph_live;
	assign trip_req[SRC_INV]   = inv_trip;
	assign trip_req[SRC_MOT]   = mot_full & mot_thermal_alarm_i;
	assign src_live[SRC_EXT]   = ext_fault_active_i;
	assign src_live[SRC_OVER]  = v_high | v_over;
	assign src_live[SRC_UNDER] = v_low | v_under;
	assign src_live[SRC_LZ]    = lz_live;
	assign src_live[SRC_PHASE] = ph_live;
	assign src_live[SRC_INV]   = inv_warn;
	assign src_live[SRC_MOT]   = mot_full;

	// highest-priority requesting source
	dfs_src_t new_src;
	always_comb begin
		new_src = SRC_NONE;
		for (int i = 6; i >= 0; i--) begin
			if (trip_req[i])
				new_src = dfs_src_t'(3'(i));
		end
	end
	wire [6:0] new_code = src_code(new_src, ext_fault_code_i);
	// class of the winning source, kept as a net so one bit can be taken
	wire [2:0] new_cls  = fault_class(new_code);
	wire       new_lock = new_cls[0];

	// any warning currently present, and its code
	wire mot_warn = mot_full & ~mot_thermal_alarm_i;
	wire lz_warn  = lz_live & ~live_zero_alarm_i;
	// low and undervoltage warnings show together at power-down
	wire any_warn = ext_warn | v_high | v_over | v_low | v_under
		| lz_warn | ph_live | inv_warn | mot_warn;
	logic [6:0] warn_code;
	always_comb begin
		warn_code = CODE_NONE;
		if (mot_warn)       warn_code = CODE_MOT_LOAD;
		if (inv_warn)       warn_code = CODE_INV_LOAD;
		if (ph_live)        warn_code = CODE_PHASE;
		if (lz_warn)        warn_code = CODE_LIVE_ZERO;
		if (v_low)          warn_code = CODE_V_LOW;
		if (v_under)        warn_code = CODE_UNDERVOLT;
		if (v_high)         warn_code = CODE_V_HIGH;
		if (v_over)         warn_code = CODE_OVERVOLT;
		if (ext_warn)       warn_code = ext_fault_code_i;
	end

	// ========================================================
	// trip state
	logic     trip_reg;
	logic     lock_reg;
	logic     off_seen_reg;
	dfs_src_t src_reg;
	logic [6:0] code_reg;

	wire cause_live = (src_reg != SRC_NONE) && src_live[src_reg];
	wire manual_rst = panel_reset_i | din_reset_i | serial_reset_i;
	// automatic reset only once the cause has gone
	wire auto_rst   = auto_reset_en_i & ~cause_live;
	// inverter overload trip stays until counter below 90 percent
	wire rst_block  = (src_reg == SRC_INV) & inv_hold;
	wire rst_ok     = (manual_rst | auto_rst) & ~rst_block & mains_ok_i;
	// locked trip needs mains removed and restored before reset
	wire clr_trip   = trip_reg & rst_ok & (~lock_reg | off_seen_reg);

	// remember a mains loss while locked; a clear wins over a mains loss
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			off_seen_reg <= 1'b0;
		else if (!lock_reg || clr_trip)
			off_seen_reg <= 1'b0;
		else if (!mains_ok_i)
			off_seen_reg <= 1'b1;
	end

	// trip latch: first trip holds its code; a locking trip adds lock
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trip_reg <= 1'b0;
			lock_reg <= 1'b0;
			src_reg  <= SRC_NONE;
			code_reg <= CODE_NONE;
		end else if (trip_req != 7'h00 && (!trip_reg || clr_trip)) begin
			trip_reg <= 1'b1;
			lock_reg <= new_lock;
			src_reg  <= new_src;
			code_reg <= new_code;
		end else if (clr_trip) begin
			trip_reg <= 1'b0;
			lock_reg <= 1'b0;
			src_reg  <= SRC_NONE;
			code_reg <= CODE_NONE;
		end else if (trip_reg && new_lock) begin
			lock_reg <= 1'b1;
		end
	end

	// ========================================================
	// outputs, all registered
	wire warn_lamp  = any_warn | (trip_reg & cause_live) | lock_reg;
	wire alarm_lamp = trip_reg;
	// inverter stops outside the hard limits while motor keeps running
	// on warnings alone
	wire inv_off    = trip_reg | v_over | v_under;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			warning_led_o  <= 1'b0;
			alarm_led_o    <= 1'b0;
			tripped_o      <= 1'b0;
			trip_locked_o  <= 1'b0;
			coast_o        <= 1'b0;
			inverter_off_o <= 1'b0;
			ready_o        <= 1'b0;
			trip_code_o    <= CODE_NONE;
		end else begin
			warning_led_o  <= warn_lamp & blink_reg;
			alarm_led_o    <= alarm_lamp & blink_reg;
			tripped_o      <= trip_reg;
			trip_locked_o  <= lock_reg;
			coast_o        <= trip_reg;
			inverter_off_o <= inv_off;
			ready_o        <= ~trip_reg;
			trip_code_o    <= code_reg;
		end
	end

	// most recent fault: a trip takes precedence over a warning
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i)
			last_fault_code_o <= CODE_NONE;
		else if (trip_req != 7'h00 && !trip_reg)
			last_fault_code_o <= new_code;
		else if (any_warn && !trip_reg)
			last_fault_code_o <= warn_code;
	end
endmodule
`default_nettype wire
